// ===== hub_pkg.sv
// package: constants, types and register map of the host serial port with break reset
//==============================================================================
package hub_pkg;

  //==============================================================================
  // clock and rate
  localparam int unsigned HUB_CLK_HZ   = 10_000_000;
  localparam int unsigned HUB_OVS      = 16;
  // rate = setting / 0.004096, so ticks per clock = setting * 16 * 1e6 / (4096 * clk)
  localparam int unsigned HUB_RATE_NUM = 4096;
  localparam int unsigned HUB_RATE_DEN = 1_000_000;
  localparam logic [16:0] HUB_ACC_MOD  =
    17'(64'(HUB_CLK_HZ) * HUB_RATE_NUM / (64'(HUB_RATE_DEN) * HUB_OVS));
  localparam logic [3:0]  HUB_TK_LAST  = 4'h f;
  localparam logic [3:0]  HUB_TK_MID   = 4'h 7;
  localparam logic [2:0]  HUB_BIT_LAST = 3'h 7;

  //==============================================================================
  // register map, byte addresses
  localparam logic [7:0] HUB_A_CTRL  = 8'h 00;
  localparam logic [7:0] HUB_A_DIV   = 8'h 04;
  localparam logic [7:0] HUB_A_BRKTO = 8'h 08;
  localparam logic [7:0] HUB_A_STAT  = 8'h 0c;
  localparam logic [7:0] HUB_A_MASK  = 8'h 10;
  localparam logic [7:0] HUB_A_TXD   = 8'h 14;
  localparam logic [7:0] HUB_A_RXD   = 8'h 18;
  localparam logic [7:0] HUB_A_LINE  = 8'h 1c;

  localparam logic [15:0] HUB_DIV_RST   = 16'h 01d8;
  localparam logic [15:0] HUB_BRKTO_RST = 16'h 01a4;

  //==============================================================================
  // control, status and line fields
  typedef enum logic [1:0] {HUB_PAR_NONE, HUB_PAR_ODD, HUB_PAR_EVEN} hub_par_e;

  typedef struct packed {
    logic     send_break;
    logic     two_stop;
    hub_par_e parity;
    logic     flow_en;
  } hub_ctrl_s;

  typedef struct packed {
    logic overrun;
    logic break_seen;
    logic frame_err;
    logic parity_err;
    logic tx_done;
    logic rx_done;
  } hub_evt_s;

  // serial pins; each output carries its own enable
  typedef struct packed {
    logic rx;
    logic cts_n;
  } hub_ser_i_s;

  typedef struct packed {
    logic tx;
    logic tx_oe;
    logic rts_n;
    logic rts_n_oe;
  } hub_ser_o_s;

  typedef enum logic [2:0] {HUB_IDLE, HUB_START, HUB_DATA, HUB_PARB, HUB_STOP} hub_fsm_e;

endpackage

// ===== hub_baud_gen.sv
// module: fractional oversample tick generator driven by the divisor setting
`timescale 1ns/10ps
module hub_baud_gen (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // rate setting and tick
  input  wire logic [15:0] div_i,
  output logic             ovs_tick_o
);
  import hub_pkg::*;

  typedef struct packed {
    logic [16:0] acc;
    logic        tick;
  } hub_bg_s;

  hub_bg_s s_q;
  hub_bg_s s_d;
  logic [16:0] sum;

  //==============================================================================
  // accumulator; a setting above the modulus saturates at one tick per clock,
  // so the top rate is clk/16 here
  always_comb begin
    s_d = s_q;
    sum = s_q.acc + {1'b0, div_i};
    s_d.tick = 1'b0;
    if (sum >= HUB_ACC_MOD) begin
      s_d.tick = 1'b1;
      s_d.acc = (sum - HUB_ACC_MOD >= HUB_ACC_MOD) ? 17'h0_0000 : sum - HUB_ACC_MOD;
    end else begin
      s_d.acc = sum;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ovs_tick_o = s_q.tick;

  property p_tick_on_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (s_q.acc + {1'b0, div_i} >= HUB_ACC_MOD) |=> ovs_tick_o;
  endproperty
  a_tick_on_wrap: assert property (p_tick_on_wrap)
    else $error("tick missing after accumulator wrap");

endmodule

// ===== hub_uart.sv
// module: host serial port with register bus, framing, flow control and break reset
`timescale 1ns/10ps
module hub_uart (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // serial pins
  input  wire hub_pkg::hub_ser_i_s ser_i,
  output hub_pkg::hub_ser_o_s      ser_o,
  // system
  output logic                     irq,
  output logic                     chip_reset_req
);
  import hub_pkg::*;

  typedef struct packed {
    logic [2:0]  rx_sync;
    logic [2:0]  cts_sync;
    logic        rx_f;
    logic        cts_f;
    logic        oe;
    logic        dp_v;
    logic        dp_w;
    logic [7:0]  dp_a;
    logic        rd_done;
    logic [31:0] rdata;
    hub_ctrl_s   ctrl;
    logic [15:0] div;
    logic [15:0] brk_to;
    hub_evt_s    stat;
    hub_evt_s    mask;
    logic [7:0]  txh;
    logic        txh_full;
    hub_fsm_e    tx_st;
    logic [3:0]  tx_tk;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic        tx_stop2;
    logic        tx;
    hub_fsm_e    rx_st;
    logic [3:0]  rx_tk;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [7:0]  rxd;
    logic        rx_full;
    logic [3:0]  brk_sub;
    logic [15:0] brk_cnt;
    logic        brk_fired;
    logic        rst_req;
    logic        rts_n;
  } hub_state_s;

  hub_state_s s_q;
  hub_state_s s_d;
  logic       ovs_tick;
  hub_evt_s   ev;
  hub_evt_s   clr;
  logic       wr;
  logic       rd;
  logic       tx_line;

  hub_baud_gen u_baud (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .div_i      (s_q.div),
    .ovs_tick_o (ovs_tick)
  );

  //==============================================================================
  // next state
  always_comb begin
    s_d = s_q;
    ev = '0;
    clr = '0;
    tx_line = 1'b1;
    s_d.rst_req = 1'b0;
    s_d.oe = 1'b1;

    // pins settle through three flops; a level counts once flops two and three agree
    s_d.rx_sync = {s_q.rx_sync[1:0], ser_i.rx};
    s_d.cts_sync = {s_q.cts_sync[1:0], ser_i.cts_n};
    if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
      s_d.rx_f = s_q.rx_sync[2];
    end
    if (s_q.cts_sync[1] == s_q.cts_sync[2]) begin
      s_d.cts_f = s_q.cts_sync[2];
    end

    // bus: writes complete with no wait; a read waits one cycle so that
    // it always sees the effect of a write just before it
    wr = s_q.dp_v && s_q.dp_w;
    rd = s_q.dp_v && !s_q.dp_w && !s_q.rd_done;
    if (hsel && hready && htrans[1]) begin
      s_d.dp_v = 1'b1;
      s_d.dp_w = hwrite;
      s_d.dp_a = haddr[7:0];
      s_d.rd_done = 1'b0;
    end else if (hready) begin
      s_d.dp_v = 1'b0;
    end
    if (wr) begin
      unique case (s_q.dp_a)
        HUB_A_CTRL:  s_d.ctrl = hub_ctrl_s'(hwdata[$bits(hub_ctrl_s)-1:0]);
        HUB_A_DIV:   s_d.div = hwdata[15:0];
        HUB_A_BRKTO: s_d.brk_to = hwdata[15:0];
        HUB_A_STAT:  clr = hub_evt_s'(hwdata[$bits(hub_evt_s)-1:0]);
        HUB_A_MASK:  s_d.mask = hub_evt_s'(hwdata[$bits(hub_evt_s)-1:0]);
        HUB_A_TXD: begin
          // a write while the holding byte is still waiting is dropped
          if (!s_q.txh_full) begin
            s_d.txh = hwdata[7:0];
            s_d.txh_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      s_d.rd_done = 1'b1;
      unique case (s_q.dp_a)
        HUB_A_CTRL:  s_d.rdata = 32'(s_q.ctrl);
        HUB_A_DIV:   s_d.rdata = 32'(s_q.div);
        HUB_A_BRKTO: s_d.rdata = 32'(s_q.brk_to);
        HUB_A_STAT:  s_d.rdata = 32'(s_q.stat);
        HUB_A_MASK:  s_d.rdata = 32'(s_q.mask);
        HUB_A_TXD:   s_d.rdata = 32'(s_q.txh);
        HUB_A_RXD: begin
          s_d.rdata = 32'(s_q.rxd);
          s_d.rx_full = 1'b0;
        end
        HUB_A_LINE:  s_d.rdata = 32'({s_q.tx_st != HUB_IDLE, s_q.txh_full, s_q.rx_full,
                                      s_q.rx_f, s_q.cts_f});
        default:     s_d.rdata = 32'h0000_0000;
      endcase
    end

    //==========================================================================
    // transmitter
    if (s_q.tx_st == HUB_IDLE) begin
      if (s_q.txh_full && !s_q.ctrl.send_break
          && (!s_q.ctrl.flow_en || !s_q.cts_f)) begin
        s_d.tx_st = HUB_START;
        s_d.tx_sh = s_q.txh;
        s_d.txh_full = 1'b0;
        s_d.tx_tk = '0;
        s_d.tx_par = 1'b0;
        s_d.tx_stop2 = 1'b0;
      end
    end else if (ovs_tick) begin
      s_d.tx_tk = s_q.tx_tk + 4'h1;
      if (s_q.tx_tk == HUB_TK_LAST) begin
        unique case (s_q.tx_st)
          HUB_START: begin
            s_d.tx_st = HUB_DATA;
            s_d.tx_bit = '0;
          end
          HUB_DATA: begin
            s_d.tx_par = s_q.tx_par ^ s_q.tx_sh[0];
            s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
            s_d.tx_bit = s_q.tx_bit + 3'h1;
            if (s_q.tx_bit == HUB_BIT_LAST) begin
              s_d.tx_st = (s_q.ctrl.parity == HUB_PAR_NONE) ? HUB_STOP : HUB_PARB;
            end
          end
          HUB_PARB: s_d.tx_st = HUB_STOP;
          HUB_STOP: begin
            if (s_q.ctrl.two_stop && !s_q.tx_stop2) begin
              s_d.tx_stop2 = 1'b1;
            end else begin
              s_d.tx_st = HUB_IDLE;
              ev.tx_done = 1'b1;
            end
          end
          default: s_d.tx_st = HUB_IDLE;
        endcase
      end
    end
    // the line level is a function of the next state so pin and state agree
    unique case (s_d.tx_st)
      HUB_START: tx_line = 1'b0;
      HUB_DATA:  tx_line = s_d.tx_sh[0];
      HUB_PARB:  tx_line = (s_d.ctrl.parity == HUB_PAR_ODD) ? ~s_d.tx_par : s_d.tx_par;
      default:   tx_line = 1'b1;
    endcase
    s_d.tx = tx_line && !s_d.ctrl.send_break;

    //==========================================================================
    // receiver, sampling at mid-bit
    if (s_q.rx_st == HUB_IDLE) begin
      if (!s_q.rx_f) begin
        s_d.rx_st = HUB_START;
        s_d.rx_tk = '0;
      end
    end else if (ovs_tick) begin
      s_d.rx_tk = s_q.rx_tk + 4'h1;
      unique case (s_q.rx_st)
        HUB_START: begin
          if (s_q.rx_tk == HUB_TK_MID) begin
            // a short glitch is not a start bit
            s_d.rx_st = s_q.rx_f ? HUB_IDLE : HUB_DATA;
            s_d.rx_tk = '0;
            s_d.rx_bit = '0;
            s_d.rx_par = 1'b0;
          end
        end
        HUB_DATA: begin
          if (s_q.rx_tk == HUB_TK_LAST) begin
            s_d.rx_sh = {s_q.rx_f, s_q.rx_sh[7:1]};
            s_d.rx_par = s_q.rx_par ^ s_q.rx_f;
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == HUB_BIT_LAST) begin
              s_d.rx_st = (s_q.ctrl.parity == HUB_PAR_NONE) ? HUB_STOP : HUB_PARB;
            end
          end
        end
        HUB_PARB: begin
          if (s_q.rx_tk == HUB_TK_LAST) begin
            ev.parity_err = (s_q.rx_par ^ s_q.rx_f) != (s_q.ctrl.parity == HUB_PAR_ODD);
            s_d.rx_st = HUB_STOP;
          end
        end
        HUB_STOP: begin
          // only the first stop bit is checked; a second one reads as idle
          if (s_q.rx_tk == HUB_TK_LAST) begin
            ev.frame_err = !s_q.rx_f;
            ev.rx_done = 1'b1;
            ev.overrun = s_d.rx_full;
            s_d.rxd = s_q.rx_sh;
            s_d.rx_full = 1'b1;
            s_d.rx_st = HUB_IDLE;
          end
        end
        default: s_d.rx_st = HUB_IDLE;
      endcase
    end
    // request-to-send high tells the host to hold off
    s_d.rts_n = s_q.ctrl.flow_en && s_q.rx_full;

    //==========================================================================
    // break detection: count whole bit times of unbroken low on the line
    if (s_q.rx_f) begin
      s_d.brk_sub = '0;
      s_d.brk_cnt = '0;
      s_d.brk_fired = 1'b0;
    end else begin
      if (ovs_tick) begin
        s_d.brk_sub = s_q.brk_sub + 4'h1;
        if (s_q.brk_sub == HUB_TK_LAST && s_q.brk_cnt != 16'h ffff) begin
          s_d.brk_cnt = s_q.brk_cnt + 16'h0001;
        end
      end
      if (s_q.brk_cnt > s_q.brk_to && !s_q.brk_fired) begin
        s_d.brk_fired = 1'b1;
        s_d.rst_req = 1'b1;
        ev.break_seen = 1'b1;
      end
    end

    // sticky status: an event in the clearing cycle survives
    s_d.stat = hub_evt_s'((s_q.stat & ~clr) | ev);
  end

  //==============================================================================
  // single state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.rx_sync <= 3'h7;
      s_q.cts_sync <= 3'h7;
      s_q.rx_f <= 1'b1;
      s_q.cts_f <= 1'b1;
      s_q.div <= HUB_DIV_RST;
      s_q.brk_to <= HUB_BRKTO_RST;
      s_q.tx <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //==============================================================================
  // outputs
  assign hreadyout = !(s_q.dp_v && !s_q.dp_w && !s_q.rd_done);
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign irq = |(s_q.stat & s_q.mask);
  assign chip_reset_req = s_q.rst_req;
  // both outputs float together until the first clock after reset
  assign ser_o.tx = s_q.tx;
  assign ser_o.rts_n = s_q.rts_n;
  assign ser_o.tx_oe = s_q.oe;
  assign ser_o.rts_n_oe = s_q.oe;

  //==============================================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_idle_high;
    (s_q.tx_st == HUB_IDLE && !s_q.ctrl.send_break) |-> ser_o.tx;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("transmit line not high while idle");

  property p_start_low;
    (s_q.tx_st == HUB_START) |-> !ser_o.tx;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_break_tx;
    s_q.ctrl.send_break |-> !ser_o.tx;
  endproperty
  a_break_tx: assert property (p_break_tx)
    else $error("break requested but line high");

  property p_oe_on;
    $past(hresetn) |-> (ser_o.tx_oe && ser_o.rts_n_oe);
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("port outputs not enabled after reset");

  property p_cts_gate;
    (s_q.tx_st == HUB_IDLE && s_q.ctrl.flow_en && s_q.cts_f) |=> (s_q.tx_st == HUB_IDLE);
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("character started without clear to send");

  property p_rts_full;
    (s_q.ctrl.flow_en && s_q.rx_full) |=> ser_o.rts_n;
  endproperty
  a_rts_full: assert property (p_rts_full)
    else $error("request to send low while receive byte unread");

  property p_flow_off;
    !s_q.ctrl.flow_en |=> !ser_o.rts_n;
  endproperty
  a_flow_off: assert property (p_flow_off)
    else $error("request to send high with flow control off");

  property p_par_only;
    (s_q.tx_st == HUB_PARB) |-> (s_q.ctrl.parity != HUB_PAR_NONE);
  endproperty
  a_par_only: assert property (p_par_only)
    else $error("parity bit sent with parity off");

  sequence s_long_low;
    !s_q.rx_f && s_q.brk_cnt > s_q.brk_to && !s_q.brk_fired;
  endsequence
  property p_break_reset;
    s_long_low |=> (chip_reset_req && s_q.stat.break_seen) ##1 !chip_reset_req;
  endproperty
  a_break_reset: assert property (p_break_reset)
    else $error("long break did not give one reset pulse");

endmodule

// ===== hub_host_model.sv
// partner model: host side of the serial link, frames and captures bytes
`timescale 1ns/10ps
module hub_host_model (
  // clock
  input  wire logic        hclk,
  // serial lines as seen from the host
  input  wire logic        line_tx,
  output logic             line_rx,
  // framing shared by both directions
  input  wire logic [1:0]  par_mode,
  input  wire logic [31:0] bit_clks
);
  logic [7:0] got_byte;
  logic       got_par;
  logic       got_stop;
  int         got_cnt;

  // the host only ever drives the receive line, never a device output
  initial begin
    line_rx = 1'b1;
    got_cnt = 0;
  end

  //==============================================================================
  // decode device frames, sampling at mid-bit
  always begin
    @(negedge line_tx);
    repeat (bit_clks / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge hclk);
      got_byte[i] = line_tx;
    end
    if (par_mode != 2'h0) begin
      repeat (bit_clks) @(posedge hclk);
      got_par = line_tx;
    end
    repeat (bit_clks) @(posedge hclk);
    got_stop = line_tx;
    got_cnt++;
  end

  //==============================================================================
  // send one frame; bad flips the parity bit on purpose
  task automatic send_byte(input logic [7:0] b, input logic two, input logic bad);
    @(posedge hclk);
    line_rx <= 1'b0;
    repeat (bit_clks) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      line_rx <= b[i];
      repeat (bit_clks) @(posedge hclk);
    end
    if (par_mode != 2'h0) begin
      line_rx <= ^b ^ (par_mode == 2'h1) ^ bad;
      repeat (bit_clks) @(posedge hclk);
    end
    line_rx <= 1'b1;
    repeat (two ? 2 * bit_clks : bit_clks) @(posedge hclk);
  endtask

  task automatic hold_low(input int n);
    @(posedge hclk);
    line_rx <= 1'b0;
    repeat (n) @(posedge hclk);
    line_rx <= 1'b1;
  endtask
endmodule

// ===== hub_uart_tb_top.sv
// testbench: register bus, framing, flow control, interrupts and break handling
`timescale 1ns/10ps
module hub_uart_tb_top;
  import hub_pkg::*;
  typedef struct {logic [15:0] div; logic [4:0] ctrl; logic [7:0] b;} hub_row_s;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, chip_reset_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, par_mode;
  logic        cts_n, rx_line, tx_line;
  hub_ser_i_s  ser_i;
  hub_ser_o_s  ser_o;
  int          bit_clks, error_cnt, checks_done, n, c;
  // 2560 gives one tick per clock, 1280 half that rate
  hub_row_s    rows [4] = '{'{16'h0a00, 5'h00, 8'ha5}, '{16'h0a00, 5'h0a, 8'h3c},
                            '{16'h0a00, 5'h04, 8'h01}, '{16'h0500, 5'h00, 8'h80}};

  // a released transmit line is pulled up to idle
  assign tx_line = ser_o.tx_oe ? ser_o.tx : 1'b1;
  assign ser_i   = '{rx: rx_line, cts_n: cts_n};

  hub_uart DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ser_i(ser_i), .ser_o(ser_o), .irq(irq), .chip_reset_req(chip_reset_req));

  hub_host_model u_host (.hclk(hclk), .line_tx(tx_line), .line_rx(rx_line),
    .par_mode(par_mode), .bit_clks(bit_clks));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  //==============================================================================
  // checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //==============================================================================
  // single-word bus transfers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask

  task automatic wait_tx(input int c0);
    n = 0;
    while (u_host.got_cnt == c0 && n < 4000) begin
      @(posedge hclk);
      n++;
    end
    // a frame that never arrives counts as a mismatch
    check(n < 4000, 1'b1);
  endtask

  // watchdog: far beyond the few thousand cycles the run needs
  initial begin
    #5_000_000;
    error_cnt++;
    wrap_up();
  end

  //==============================================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    cts_n = 1'b0;
    par_mode = 2'h0;
    bit_clks = 16;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge hclk);
    check(ser_o.tx_oe, 1'b0);
    check(ser_o.rts_n_oe, 1'b0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check({ser_o.tx_oe, ser_o.rts_n_oe, tx_line, ser_o.rts_n}, 4'he);
    rd(HUB_A_DIV, 32'h0000_01d8);
    rd(HUB_A_BRKTO, 32'h0000_01a4);
    rd(8'h20, 32'h0000_0000);
    check(hresp, 1'b0);
    wr(HUB_A_MASK, 32'h0000_0001);
    foreach (rows[i]) begin
      wr(HUB_A_DIV, {16'h0000, rows[i].div});
      wr(HUB_A_CTRL, {27'h000_0000, rows[i].ctrl});
      par_mode = rows[i].ctrl[2:1];
      bit_clks = 16 * 2560 / rows[i].div;
      c = u_host.got_cnt;
      wr(HUB_A_TXD, {24'h00_0000, rows[i].b});
      wait_tx(c);
      check(u_host.got_byte, rows[i].b);
      if (par_mode != 2'h0)
        check(u_host.got_par, ^rows[i].b ^ (par_mode == 2'h1));
      check(u_host.got_stop, 1'b1);
      u_host.send_byte(rows[i].b, rows[i].ctrl[3], 1'b0);
      repeat (4) @(posedge hclk);
      check(irq, 1'b1);
      rd(HUB_A_RXD, {24'h00_0000, rows[i].b});
      rd(HUB_A_STAT, 32'h0000_0003);
      wr(HUB_A_STAT, 32'h0000_003f);
      @(negedge hclk);
      check(irq, 1'b0);
    end
    // wrong parity from the host, then mask it away
    wr(HUB_A_DIV, 32'h0000_0a00);
    bit_clks = 16;
    wr(HUB_A_CTRL, 32'h0000_0004);
    par_mode = 2'h2;
    wr(HUB_A_MASK, 32'h0000_0004);
    u_host.send_byte(8'h5a, 1'b0, 1'b1);
    repeat (4) @(posedge hclk);
    check(irq, 1'b1);
    rd(HUB_A_STAT, 32'h0000_0005);
    wr(HUB_A_MASK, 32'h0000_0000);
    @(negedge hclk);
    check(irq, 1'b0);
    rd(HUB_A_RXD, 32'h0000_005a);
    wr(HUB_A_STAT, 32'h0000_003f);
    // flow control: hold off while clear-to-send is high
    wr(HUB_A_CTRL, 32'h0000_0001);
    par_mode = 2'h0;
    cts_n <= 1'b1;
    // let the pin synchroniser see clear-to-send high before a byte is queued
    repeat (4) @(posedge hclk);
    c = u_host.got_cnt;
    wr(HUB_A_TXD, 32'h0000_0055);
    repeat (100) @(posedge hclk);
    check(u_host.got_cnt, c);
    check(tx_line, 1'b1);
    rd(HUB_A_LINE, 32'h0000_000b);
    cts_n <= 1'b0;
    wait_tx(c);
    check(u_host.got_byte, 8'h55);
    u_host.send_byte(8'h11, 1'b0, 1'b0);
    repeat (4) @(posedge hclk);
    check(ser_o.rts_n, 1'b1);
    rd(HUB_A_RXD, 32'h0000_0011);
    @(negedge hclk);
    check(ser_o.rts_n, 1'b0);
    // transmit break for the host wake-up
    repeat (200) @(posedge hclk);
    wr(HUB_A_CTRL, 32'h0000_0010);
    repeat (20) @(posedge hclk);
    check({ser_o.tx_oe, tx_line}, 2'h2);
    repeat (200) @(posedge hclk);
    wr(HUB_A_CTRL, 32'h0000_0000);
    @(negedge hclk);
    check(tx_line, 1'b1);
    // receive break longer than four bit times requests a chip reset
    wr(HUB_A_BRKTO, 32'h0000_0004);
    wr(HUB_A_STAT, 32'h0000_003f);
    fork
      u_host.hold_low(200);
      begin
        n = 0;
        while (chip_reset_req !== 1'b1 && n < 200) begin
          @(posedge hclk);
          n++;
        end
      end
    join
    check(n > 64 && n < 100, 1'b1);
    bus(1'b0, HUB_A_STAT, 32'h0000_0000);
    check(q[4], 1'b1);
    check(q[3], 1'b1);
    // reset in mid-run floats the port again
    hresetn <= 1'b0;
    @(negedge hclk);
    check({ser_o.tx_oe, ser_o.rts_n_oe}, 2'h0);
    wrap_up();
  end
endmodule
